// ==== rtl/adc_cfg_pkg.sv ====
package adc_cfg_pkg;
  localparam int DATA_W = 12;
  localparam int CFG_W = 10;
  localparam int ADDR_LO = 10;
  localparam int ADDR_HI = 11;
  localparam logic [1:0] CFG0_ADDR = 2'h0;
  localparam logic [CFG_W-1:0] CFG0_RESET = 10'h020;
  localparam int REF_SEL_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam int POWER_DOWN_BIT = 2;
  localparam int INPUT_PICK_LO = 3;
  localparam int INPUT_PICK_HI = 4;
  localparam int DIFF_COUNT_LO = 5;
  localparam int DIFF_COUNT_HI = 6;
  localparam int SCAN_BIT = 7;
  localparam int SELFTEST_LO = 8;
  localparam int SELFTEST_HI = 9;
  localparam int SYNC_STAGES = 3;
  localparam int CHAN_W = 3;
  // Channel codes driven towards the FIFO tag (fifoChannel)
  localparam logic [CHAN_W-1:0] CH_AINP = 3'h0;
  localparam logic [CHAN_W-1:0] CH_AINM = 3'h1;
  localparam logic [CHAN_W-1:0] CH_BINP = 3'h2;
  localparam logic [CHAN_W-1:0] CH_BINM = 3'h3;
  localparam logic [CHAN_W-1:0] CH_DIFF_A = 3'h4;
  localparam logic [CHAN_W-1:0] CH_DIFF_B = 3'h5;
endpackage

// ==== rtl/adc_conversion_config_reg0.sv ====
`timescale 1ns/1ps
// Operation
// - Bit 0 resets to 0 for the internal reference; 1 picks external.
// - Mode bit 1 at 0 (reset): one FIFO write per falling clock edge.
// - Mode bit 1 at 1: single conversion, clock pin is a start strobe.
// - A falling strobe holds all selected inputs and starts the scan.
// - Data-available fires once trigger-level results are written.
// - Bit 2 resets to 0 (active); 1 powers the converter down.
// - In power-down, writes, output reads and FIFO reads still work.
// - Select bits 3 and 4 reset to zero and pick the input channel.
// - Differential count bits 5 and 6 reset to 1 and 0.
// - Bit 7 resets to 0; autoscan writes channels in a fixed order.
// - Test bits 8 and 9 reset to zero; nonzero picks a test voltage.
// - While a test setting is active data-available stays off.
// - Value on lines 0 to 9; lines 10 and 11 both 0 pick this register.
module adc_conversion_config_reg0
  import adc_cfg_pkg::*;
#(
  parameter int TRIG_W = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] dataIn,
  input wire logic writeStrobe,
  input wire logic conversionClockIn,
  input wire logic [TRIG_W-1:0] triggerLevel,
  output logic [adc_cfg_pkg::CFG_W-1:0] configOut,
  output logic refExternal,
  output logic powerDown,
  output logic [1:0] selftestSel,
  output logic sampleHold,
  output logic fifoWrite,
  output logic [adc_cfg_pkg::CHAN_W-1:0] fifoChannel,
  output logic converting,
  output logic resultsReadyOut
);
  import adc_cfg_pkg::*;

  typedef enum logic [0:0] {IDLE, SEQUENCE} conv_state_e;

  if (TRIG_W < 2 || TRIG_W > 8) begin : bad_trig_w
    $error("TRIG_W must lie between 2 and 8");
  end

  logic [CFG_W-1:0] cfg;
  logic [SYNC_STAGES-1:0] wrSync;
  logic [SYNC_STAGES-1:0] ckSync;
  logic wrLevel;
  logic ckLevel;
  logic wrRise;
  logic ckFall;
  logic cfgWrite;
  conv_state_e state;
  logic [1:0] seqIdx;
  logic [2:0] seqLen;
  logic [CHAN_W-1:0] seqChan;
  logic [TRIG_W-1:0] writeCount;
  logic [TRIG_W-1:0] next_writeCount;
  logic singleMode;
  logic testActive;
  logic lastStep;
  logic doWrite;

  // Pins pass three flops; a change counts when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrSync <= '0;
      ckSync <= {SYNC_STAGES{1'b1}};
    end else begin
      wrSync <= {wrSync[SYNC_STAGES-2:0], writeStrobe};
      ckSync <= {ckSync[SYNC_STAGES-2:0], conversionClockIn};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrLevel <= 1'b0;
      ckLevel <= 1'b1;
    end else begin
      if (wrSync[1] == wrSync[2]) begin
        wrLevel <= wrSync[2];
      end
      if (ckSync[1] == ckSync[2]) begin
        ckLevel <= ckSync[2];
      end
    end
  end

  assign wrRise = (wrSync[1] == wrSync[2]) && wrSync[2] && !wrLevel;
  assign ckFall = (ckSync[1] == ckSync[2]) && !ckSync[2] && ckLevel;

  // Data lines are held stable across the strobe, so sampling here is safe
  assign cfgWrite = wrRise
    && ({dataIn[ADDR_HI], dataIn[ADDR_LO]} == CFG0_ADDR);

  // Writes are honoured in power-down too
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg <= CFG0_RESET;
    end else if (cfgWrite) begin
      cfg <= dataIn[CFG_W-1:0];
    end
  end

  assign configOut = cfg;
  assign refExternal = cfg[REF_SEL_BIT];
  assign powerDown = cfg[POWER_DOWN_BIT];
  assign selftestSel = cfg[SELFTEST_HI:SELFTEST_LO];
  assign singleMode = cfg[MODE_BIT];
  assign testActive = |cfg[SELFTEST_HI:SELFTEST_LO];

  // Scan order per scan/diff/select code; reserved codes fall back to one
  always_comb begin
    seqLen = 3'h1;
    seqChan = {1'b0, cfg[INPUT_PICK_HI:INPUT_PICK_LO]};
    case (cfg[SCAN_BIT:INPUT_PICK_LO])
      5'h04: seqChan = CH_DIFF_A;
      5'h05: seqChan = CH_DIFF_B;
      5'h11: begin
        seqLen = 3'h2;
        seqChan = seqIdx[0] ? CH_AINM : CH_AINP;
      end
      5'h12: begin
        seqLen = 3'h3;
        seqChan = {1'b0, seqIdx};
      end
      5'h13: begin
        seqLen = 3'h4;
        seqChan = {1'b0, seqIdx};
      end
      5'h15: begin
        seqLen = 3'h2;
        seqChan = seqIdx[0] ? CH_DIFF_B : CH_AINP;
      end
      5'h16: begin
        seqLen = 3'h3;
        seqChan = (seqIdx == 2'h2) ? CH_DIFF_B : {1'b0, seqIdx};
      end
      5'h19: begin
        seqLen = 3'h2;
        seqChan = seqIdx[0] ? CH_DIFF_B : CH_DIFF_A;
      end
      default: begin
        seqLen = 3'h1;
      end
    endcase
  end

  assign lastStep = ({1'b0, seqIdx} == seqLen - 3'h1);

  // Single-mode sequencer; strobes during a sequence are ignored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE: begin
          if (singleMode && ckFall && !powerDown) begin
            state <= SEQUENCE;
          end
        end
        SEQUENCE: begin
          if (lastStep || cfgWrite) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  assign converting = (state == SEQUENCE);

  // Continuous: one result per falling edge; single: one per cycle in turn
  assign doWrite = singleMode ? converting
    : (ckFall && !powerDown);

  // A new configuration restarts the scan at its first channel
  always_ff @(posedge clk_sys) begin
    if (reset || cfgWrite) begin
      seqIdx <= 2'h0;
    end else if (doWrite) begin
      seqIdx <= lastStep ? 2'h0 : seqIdx + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sampleHold <= 1'b0;
    end else begin
      sampleHold <= (singleMode && ckFall && !powerDown && !converting)
        || (!singleMode && ckFall && !powerDown);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fifoWrite <= 1'b0;
      fifoChannel <= CH_AINP;
    end else begin
      fifoWrite <= doWrite;
      fifoChannel <= seqChan;
    end
  end

  // Trigger count; held at zero in test mode so no stale block remains
  always_comb begin
    next_writeCount = writeCount;
    if (testActive) begin
      next_writeCount = '0;
    end else if (fifoWrite) begin
      next_writeCount = (writeCount + 1'b1 >= triggerLevel)
        ? '0 : writeCount + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      writeCount <= '0;
      resultsReadyOut <= 1'b0;
    end else begin
      writeCount <= next_writeCount;
      resultsReadyOut <= !testActive && fifoWrite
        && (writeCount + 1'b1 >= triggerLevel);
    end
  end

  cfg_reset_a: assert property (@(posedge clk_sys)
    $fell(reset) |-> cfg == CFG0_RESET)
    else $error("Config not at reset value after reset");

  cfg_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfgWrite |=> cfg == $past(dataIn[CFG_W-1:0]))
    else $error("Addressed write not stored");

  cfg_other_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
    (wrRise && dataIn[ADDR_LO +: 2] != CFG0_ADDR) |=> $stable(cfg))
    else $error("Write to other address changed config");

  cont_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!singleMode && !powerDown && ckFall && !cfgWrite) |=> fifoWrite)
    else $error("Continuous edge gave no FIFO write");

  pd_no_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    (powerDown && !converting && $past(powerDown)) |=> !fifoWrite)
    else $error("FIFO written while powered down");

  single_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (singleMode && ckFall && !powerDown && state == IDLE)
      |=> sampleHold && converting)
    else $error("Start strobe did not hold and start");

  single_len_a: assert property (@(posedge clk_sys) disable iff (reset)
    ($rose(converting) && seqLen == 3'h2 && !cfgWrite)
      |-> converting[*2] ##1 !converting)
    else $error("Two-channel sequence wrong length");

  test_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    testActive |=> !resultsReadyOut)
    else $error("Data-available raised in test mode");

  ready_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
    resultsReadyOut |-> $past(fifoWrite) && !$past(testActive))
    else $error("Data-available without a result write");

  ref_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfgWrite |=> refExternal == $past(dataIn[REF_SEL_BIT])
      && powerDown == $past(dataIn[POWER_DOWN_BIT]))
    else $error("Reference or power-down output mismatch");

  // A held pin level must give one edge only, so one hold per strobe
  edge_once_a: assert property (@(posedge clk_sys) disable iff (reset)
    ckFall |=> !ckFall)
    else $error("One pin edge counted twice");

  write_once_a: assert property (@(posedge clk_sys) disable iff (reset)
    cfgWrite |=> !cfgWrite)
    else $error("One write strobe stored twice");

  hold_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    sampleHold |=> !sampleHold)
    else $error("Hold pulse longer than one cycle");

  pd_no_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    powerDown |=> !sampleHold)
    else $error("Inputs held while powered down");

  mode_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!singleMode && !converting) |=> !converting)
    else $error("Sequence started in continuous mode");

  single_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    (converting && singleMode) |=> fifoWrite)
    else $error("Sequence step gave no FIFO write");

  seq_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(converting) |-> seqIdx == 2'h0)
    else $error("Sequence did not start at its first channel");

  seq_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
    {1'b0, seqIdx} < seqLen)
    else $error("Scan index beyond sequence length");

  test_count_a: assert property (@(posedge clk_sys) disable iff (reset)
    testActive |=> writeCount == '0)
    else $error("Trigger count moved in test mode");
endmodule

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  output logic [11:0] dataIn,
  output logic writeStrobe,
  output logic conversionClockIn
);
  initial begin
    dataIn = 12'hFFF;
    writeStrobe = 1'b0;
    conversionClockIn = 1'b1;
  end
  // Lines turned over once released, so stale data never looks valid
  task automatic write_reg(input logic [1:0] addr, input logic [9:0] val);
    dataIn <= {addr, val};
    writeStrobe <= 1'b1;
    repeat (6) @(posedge clk_sys);
    writeStrobe <= 1'b0;
    dataIn <= ~{addr, val};
    repeat (8) @(posedge clk_sys);
  endtask
  // Both phases 4 clocks, above the 2-clock minimum
  task automatic strobe(input int n);
    repeat (n) begin
      conversionClockIn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      conversionClockIn <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
  endtask
endmodule

// ==== testbench/adc_conversion_config_reg0_tb.sv ====
`timescale 1ns/1ps
module adc_conversion_config_reg0_tb;
  import adc_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] triggerLevel = 4'h1;
  logic [11:0] dataIn;
  logic writeStrobe, conversionClockIn, refExternal, powerDown;
  logic sampleHold, fifoWrite, converting, resultsReadyOut;
  logic [9:0] configOut;
  logic [1:0] selftestSel;
  logic [2:0] fifoChannel;
  logic [2:0] chans[$];
  int readyCnt = 0;
  int holdCnt = 0;
  int convCnt = 0;
  int err_total = 0;
  int samples_checked = 0;
  always #2 clk_sys = ~clk_sys;
  host_model host (.clk_sys(clk_sys), .dataIn(dataIn),
    .writeStrobe(writeStrobe), .conversionClockIn(conversionClockIn));
  adc_conversion_config_reg0 #(.TRIG_W(4)) dut (.clk_sys(clk_sys),
    .reset(reset), .dataIn(dataIn), .writeStrobe(writeStrobe),
    .conversionClockIn(conversionClockIn), .triggerLevel(triggerLevel),
    .configOut(configOut), .refExternal(refExternal),
    .powerDown(powerDown), .selftestSel(selftestSel),
    .sampleHold(sampleHold), .fifoWrite(fifoWrite),
    .fifoChannel(fifoChannel), .converting(converting),
    .resultsReadyOut(resultsReadyOut));
  // Sampled mid-cycle so pulses are seen settled
  always @(negedge clk_sys) begin
    if (fifoWrite === 1'b1) chans.push_back(fifoChannel);
    if (resultsReadyOut === 1'b1) readyCnt++;
    if (sampleHold === 1'b1) holdCnt++;
    if (converting === 1'b1) convCnt++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [3:0] lvl, input int n);
    triggerLevel <= lvl;
    chans.delete();
    readyCnt = 0;
    holdCnt = 0;
    convCnt = 0;
    host.strobe(n);
    repeat (16) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    check(configOut[6:3], 16'h4);
    check({configOut[9:7], configOut[2:0]}, 16'h0);
    check({refExternal, powerDown, selftestSel}, 16'h0);
  endtask
  task automatic t_addr;
    host.write_reg(2'h1, 10'h001);
    check(configOut, 16'h020);
    host.write_reg(2'h0, 10'h021);
    check(refExternal, 16'h1);
  endtask
  task automatic t_cont;
    host.write_reg(2'h0, 10'h020);
    run(4'h2, 4);
    check(chans.size(), 16'h4);
    check(chans[0], CH_DIFF_A);
    check(readyCnt, 16'h2);
    check(holdCnt, 16'h4);
  endtask
  task automatic t_single;
    host.write_reg(2'h0, 10'h09A);
    run(4'h4, 1);
    check(holdCnt, 16'h1);
    check(chans.size(), 16'h4);
    for (int i = 0; i < 4 && i < chans.size(); i++) begin
      check(chans[i], i[2:0]);
    end
    check(readyCnt, 16'h1);
    check(convCnt, 16'h4);
  endtask
  // Level equals the block length, so one pulse per block
  task automatic scan_one(input logic [9:0] val, input int n, input int k,
      input logic [11:0] exp);
    host.write_reg(2'h0, val);
    run(4'(n), k);
    check(chans.size(), 16'(n));
    for (int i = 0; i < n && i < chans.size(); i++) begin
      check(chans[i], exp[3*i +: 3]);
    end
    check(readyCnt, 16'h1);
    check(convCnt, val[MODE_BIT] ? 16'(n) : 16'h0);
    check(holdCnt, val[MODE_BIT] ? 16'h1 : 16'(k));
  endtask
  task automatic t_scan;
    scan_one(10'h08A, 2, 1, {6'h00, CH_AINM, CH_AINP});
    scan_one(10'h092, 3, 1, {3'h0, CH_BINP, CH_AINM, CH_AINP});
    scan_one(10'h0AA, 2, 1, {6'h00, CH_DIFF_B, CH_AINP});
    scan_one(10'h0B2, 3, 1, {3'h0, CH_DIFF_B, CH_AINM, CH_AINP});
    scan_one(10'h0CA, 2, 1, {6'h00, CH_DIFF_B, CH_DIFF_A});
    scan_one(10'h02A, 1, 1, {9'h000, CH_DIFF_B});
    scan_one(10'h088, 4, 4, {CH_AINM, CH_AINP, CH_AINM, CH_AINP});
  endtask
  task automatic t_pd;
    host.write_reg(2'h0, 10'h024);
    run(4'h1, 2);
    check(chans.size(), 16'h0);
    check({powerDown, configOut}, 16'h424);
    host.write_reg(2'h0, 10'h026);
    check(configOut, 16'h026);
    run(4'h1, 1);
    check(16'(chans.size() + holdCnt + convCnt), 16'h0);
  endtask
  // Results taken without waiting on data-available; full rewrite to leave
  task automatic t_test;
    host.write_reg(2'h0, 10'h120);
    check(selftestSel, 16'h1);
    run(4'h1, 2);
    check(chans.size(), 16'h2);
    check(readyCnt, 16'h0);
    host.write_reg(2'h0, 10'h020);
    check(selftestSel, 16'h0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_addr();
    t_cont();
    t_single();
    t_scan();
    t_pd();
    t_test();
    report_and_stop();
  end
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule
